// *** include/fsm_pkg.sv ***
package fsm_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_ALARM_MASK = 8'h1D;
	localparam logic [7:0] ADDR_GEN_MASK = 8'h1E;
	localparam logic [7:0] ADDR_ALARM_FLAGS = 8'h20;
	localparam logic [7:0] ADDR_GEN_FLAGS = 8'h21;
	localparam logic [7:0] ADDR_FORCE_FAIL = 8'h22;
	localparam logic [7:0] ADDR_CRC_LIMIT = 8'h23;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] ALARM_FLAGS_RST = 16'h0200;
	localparam logic [15:0] ALARM_MASK_RST = 16'hEFDF;
	localparam logic [15:0] GEN_MASK_RST = 16'hFFFF;
	// Writable bits of the two mask registers; the rest read as their reset value
	localparam logic [15:0] ALARM_MASK_RW = 16'h31FF;
	localparam logic [15:0] GEN_MASK_RW = 16'h06CF;

	// ****************************************
	// Alarm flag bit positions
	// ****************************************
	localparam int A_GENERAL_IRQ_SUMMARY = 15;
	localparam int A_SELF_DIAG = 13;
	localparam int A_OSCILLATOR_START_FAILURE = 12;
	localparam int A_LINK_CHECKSUM_ERROR_COUNT_HI = 11;
	localparam int A_LINK_CHECKSUM_ERROR_COUNT_LO = 10;
	localparam int A_TRIM_NL = 9;
	localparam int A_TRIM_CRC = 8;
	localparam int A_LINK_CRC = 7;
	localparam int A_WDOG = 6;
	localparam int A_VREF = 5;
	localparam int A_AIN1 = 4;
	localparam int A_AIN0 = 3;
	localparam int A_TEMP = 2;
	localparam int A_OT_ERR = 1;
	localparam int A_OT_WARN = 0;

	// ****************************************
	// General event bit positions
	// ****************************************
	localparam int G_ALARM_IRQ = 15;
	localparam int G_ST_DONE = 10;
	localparam int G_ST_FAIL = 9;
	localparam int G_SLEW = 7;
	localparam int G_CONV = 6;
	localparam int G_BRK_FRM = 3;
	localparam int G_BRK_PAR = 2;
	localparam int G_SER_FRM = 1;
	localparam int G_SER_PAR = 0;
	// Sticky general events: self-test done/failed, conversion and all four serial line errors
	localparam logic [15:0] GEN_STICKY = 16'h064F;

	// Counter limit code meaning a limit of eight
	localparam logic [1:0] CRC_LIMIT_8 = 2'h3;
endpackage : fsm_pkg

// *** design/fsm_fault_aggregator.sv ***
// Functional notes
// - General-event mask bit 0 lets event interrupt; 1 blocks interrupt and alarm.
// - Status flags set whenever condition occurs, regardless of mask.
// - Mask bits 10,9,7,6: selftest done, failed, slew, conversion; reset 1.
// - Mask bits 3..0: break frame, break parity, serial frame, parity; reset 1.
// - Alarm bit 15 is OR of unmasked general-event flags.
// - Bit 13 set while any self-diagnostic channel is out of limits.
// - Bit 12 oscillator start failure forces alarm, never interrupt.
// - Bits 11:10 show counter bits 1:0, or 2:1 when limit is 8.
// - Bit 9 resets 1, clears after trim load; holds alarm; no interrupt.
// - Bits 8,7,6 sticky; read clears unless condition still present.
// - Bit 7 set on a host frame with bad checksum.
// - Bit 8 set on trim memory checksum error.
// - Bit 6 set on windowed watchdog timing fault; maskable sticky.
// - Bit 5 live: invalid reference OR injection bit.
// - Bits 4,3,2 set when aux1, aux0, die temp measurement out of limits.
// - Bit 1 live: above-130C indication OR injection bit.
// - Bit 0 live: above-85C indication OR injection bit.
// - Alarm flags at 20h, power-on value 0200h.
// - General-event bit 15 is OR of unmasked alarm flags.
// - Alarm mask at 1Dh, reset EFDFh, gates flags from interrupt and alarm.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module fsm_fault_aggregator (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Alarm-side condition inputs
	input wire logic self_diag_fault,
	input wire logic oscillator_start_failure,
	input wire logic trim_load_done,
	input wire logic trim_crc_error,
	input wire logic link_crc_bad_frame,
	input wire logic watchdog_fault,
	input wire logic vref_invalid,
	input wire logic aux_input1_out_of_limit,
	input wire logic aux_input0_out_of_limit,
	input wire logic die_temp_out_of_limit,
	input wire logic temp_above_130,
	input wire logic temp_above_85,
	// General-event condition inputs
	input wire logic selftest_done,
	input wire logic selftest_failed,
	input wire logic slew_settled,
	input wire logic conversion_done,
	input wire logic break_frame_error,
	input wire logic break_parity_error,
	input wire logic serial_frame_error,
	input wire logic serial_parity_error,
	// Outputs
	output logic irq,
	output logic alarm_n
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] alarm_mask_r;
	logic [15:0] gen_mask_r;
	logic [15:0] force_fail_r;
	logic [1:0] crc_limit_r;
	logic [2:0] link_checksum_error_count_r;
	logic trim_memory_not_loaded_r;
	logic [2:0] alarm_sticky_r;
	logic [15:0] gen_sticky_r;
	logic [15:0] alarm_flags;
	logic [15:0] general_event_flags;
	logic [15:0] alarm_live;
	logic [15:0] gen_live;
	logic [15:0] alarm_unmasked;
	logic [15:0] gen_unmasked;
	logic alarm_rd;
	logic gen_rd;
	logic [1:0] crc_view;

	assign alarm_rd = reg_rd && (reg_addr == fsm_pkg::ADDR_ALARM_FLAGS);
	assign gen_rd = reg_rd && (reg_addr == fsm_pkg::ADDR_GEN_FLAGS);

	// ****************************************
	// Mask and control registers
	// ****************************************
	// Only documented mask bits are writable; reserved mask bits keep reset value; all 16 force-fail bits are writable
	always_ff @(posedge clk) begin
		if (reset) begin
			alarm_mask_r <= fsm_pkg::ALARM_MASK_RST;
			gen_mask_r <= fsm_pkg::GEN_MASK_RST;
			force_fail_r <= 16'h0000;
			crc_limit_r <= 2'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				fsm_pkg::ADDR_ALARM_MASK: begin
					alarm_mask_r <= (reg_wdata & fsm_pkg::ALARM_MASK_RW) |
						(fsm_pkg::ALARM_MASK_RST & ~fsm_pkg::ALARM_MASK_RW);
				end
				fsm_pkg::ADDR_GEN_MASK: begin
					gen_mask_r <= (reg_wdata & fsm_pkg::GEN_MASK_RW) |
						(fsm_pkg::GEN_MASK_RST & ~fsm_pkg::GEN_MASK_RW);
				end
				fsm_pkg::ADDR_FORCE_FAIL: force_fail_r <= reg_wdata;
				fsm_pkg::ADDR_CRC_LIMIT: crc_limit_r <= reg_wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Link checksum error counter
	// ****************************************
	// Saturates at seven so with the limit of eight the displayed bits never wrap back to zero; bits 1:0 wrap at four
	always_ff @(posedge clk) begin
		if (reset) begin
			link_checksum_error_count_r <= 3'h0;
		end else if (link_crc_bad_frame && link_checksum_error_count_r != 3'h7) begin
			link_checksum_error_count_r <= link_checksum_error_count_r + 3'h1;
		end
	end

	assign crc_view = (crc_limit_r == fsm_pkg::CRC_LIMIT_8) ? link_checksum_error_count_r[2:1] :
		link_checksum_error_count_r[1:0];

	// ****************************************
	// Trim memory load tracking
	// ****************************************
	// Once cleared it stays clear until the next reset
	always_ff @(posedge clk) begin
		if (reset) begin
			trim_memory_not_loaded_r <= 1'b1;
		end else if (trim_load_done) begin
			trim_memory_not_loaded_r <= 1'b0;
		end
	end

	// ****************************************
	// Sticky alarm flags (bits 8,7,6)
	// ****************************************
	// Set term wins over the read clear, so no event is lost
	always_ff @(posedge clk) begin
		if (reset) begin
			alarm_sticky_r <= 3'h0;
		end else begin
			alarm_sticky_r <= (alarm_rd ? 3'h0 : alarm_sticky_r) |
				{trim_crc_error, link_crc_bad_frame, watchdog_fault};
		end
	end

	// ****************************************
	// Sticky general-event flags
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			gen_sticky_r <= 16'h0000;
		end else begin
			gen_sticky_r <= ((alarm_rd || gen_rd) ? 16'h0000 : gen_sticky_r) |
				(gen_live & fsm_pkg::GEN_STICKY);
		end
	end

	// ****************************************
	// Flag assembly
	// ****************************************
	always_comb begin
		alarm_live = 16'h0000;
		alarm_live[fsm_pkg::A_SELF_DIAG] = self_diag_fault;
		alarm_live[fsm_pkg::A_OSCILLATOR_START_FAILURE] = oscillator_start_failure;
		alarm_live[fsm_pkg::A_LINK_CHECKSUM_ERROR_COUNT_HI] = crc_view[1];
		alarm_live[fsm_pkg::A_LINK_CHECKSUM_ERROR_COUNT_LO] = crc_view[0];
		alarm_live[fsm_pkg::A_TRIM_NL] = trim_memory_not_loaded_r;
		alarm_live[fsm_pkg::A_TRIM_CRC] = alarm_sticky_r[2];
		alarm_live[fsm_pkg::A_LINK_CRC] = alarm_sticky_r[1];
		alarm_live[fsm_pkg::A_WDOG] = alarm_sticky_r[0];
		alarm_live[fsm_pkg::A_VREF] = vref_invalid | force_fail_r[fsm_pkg::A_VREF];
		alarm_live[fsm_pkg::A_AIN1] = aux_input1_out_of_limit;
		alarm_live[fsm_pkg::A_AIN0] = aux_input0_out_of_limit;
		alarm_live[fsm_pkg::A_TEMP] = die_temp_out_of_limit;
		alarm_live[fsm_pkg::A_OT_ERR] = temp_above_130 | force_fail_r[fsm_pkg::A_OT_ERR];
		alarm_live[fsm_pkg::A_OT_WARN] = temp_above_85 | force_fail_r[fsm_pkg::A_OT_WARN];
		gen_live = 16'h0000;
		gen_live[fsm_pkg::G_ST_DONE] = selftest_done;
		gen_live[fsm_pkg::G_ST_FAIL] = selftest_failed;
		gen_live[fsm_pkg::G_CONV] = conversion_done;
		gen_live[fsm_pkg::G_BRK_FRM] = break_frame_error;
		gen_live[fsm_pkg::G_BRK_PAR] = break_parity_error;
		gen_live[fsm_pkg::G_SER_FRM] = serial_frame_error;
		gen_live[fsm_pkg::G_SER_PAR] = serial_parity_error;
		// Slew settled is a level, not sticky
		general_event_flags = gen_sticky_r | gen_live;
		general_event_flags[fsm_pkg::G_SLEW] = slew_settled;
		// Counter field and trim flag are not maskable faults
		alarm_unmasked = alarm_live & ~alarm_mask_r & fsm_pkg::ALARM_MASK_RW;
		gen_unmasked = general_event_flags & ~gen_mask_r & fsm_pkg::GEN_MASK_RW;
		general_event_flags[fsm_pkg::G_ALARM_IRQ] = |alarm_unmasked;
		alarm_flags = alarm_live;
		alarm_flags[fsm_pkg::A_GENERAL_IRQ_SUMMARY] = |gen_unmasked;
	end

	// ****************************************
	// Read data
	// ****************************************
	// Unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				fsm_pkg::ADDR_ALARM_MASK: reg_rdata <= alarm_mask_r;
				fsm_pkg::ADDR_GEN_MASK: reg_rdata <= gen_mask_r;
				fsm_pkg::ADDR_ALARM_FLAGS: reg_rdata <= alarm_flags;
				fsm_pkg::ADDR_GEN_FLAGS: reg_rdata <= general_event_flags;
				fsm_pkg::ADDR_FORCE_FAIL: reg_rdata <= force_fail_r;
				fsm_pkg::ADDR_CRC_LIMIT: reg_rdata <= {14'h0000, crc_limit_r};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ****************************************
	// Interrupt and alarm outputs
	// ****************************************
	// Oscillator failure and unloaded trim drive alarm even though they never raise irq
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
			alarm_n <= 1'b1;
		end else begin
			irq <= (|(alarm_unmasked & ~(16'h0001 << fsm_pkg::A_OSCILLATOR_START_FAILURE))) | (|gen_unmasked);
			alarm_n <= ~((|alarm_unmasked) | (|gen_unmasked) | oscillator_start_failure |
				trim_memory_not_loaded_r);
		end
	end
endmodule : fsm_fault_aggregator

// *** test/fsm_fault_monitor.sv ***
`timescale 1ns/100ps
module fsm_fault_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Conditions
	input wire logic self_diag_fault,
	input wire logic oscillator_start_failure,
	input wire logic trim_load_done,
	input wire logic trim_crc_error,
	input wire logic link_crc_bad_frame,
	input wire logic watchdog_fault,
	input wire logic temp_above_85,
	// Outputs
	input wire logic alarm_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic trim_seen_r;
	// Remember any trim load; the flag never comes back without reset
	always_ff @(posedge clk) begin
		if (reset) trim_seen_r <= 1'b0;
		else if (trim_load_done) trim_seen_r <= 1'b1;
	end
	sequence rd_alarm;
		reg_rd && reg_addr == fsm_pkg::ADDR_ALARM_FLAGS;
	endsequence
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero when idle");
	AST_TRIM_ALARM: assert property (!$past(reset) && !$past(trim_seen_r) |-> !alarm_n)
		else $error("alarm not held before trim load");
	AST_OSC_ALARM: assert property (oscillator_start_failure [*3] |-> !alarm_n)
		else $error("oscillator failure without alarm");
	AST_LINK_SET: assert property (link_crc_bad_frame ##1 rd_alarm |=> reg_rdata[7])
		else $error("link checksum flag missing");
	AST_TRIM_CRC: assert property (trim_crc_error ##1 rd_alarm |=> reg_rdata[8])
		else $error("trim checksum flag missing");
	AST_SET_WINS: assert property ((rd_alarm ##0 watchdog_fault) ##1 rd_alarm |=> reg_rdata[6])
		else $error("event lost on clearing read");
	AST_CLEAR: assert property ((rd_alarm ##0 !link_crc_bad_frame) ##1 rd_alarm |=> !reg_rdata[7])
		else $error("sticky flag not cleared by read");
	AST_SELF_DIAG: assert property (self_diag_fault [*2] ##0 rd_alarm |=> reg_rdata[13])
		else $error("self diagnostic flag missing");
	AST_OT_WARN: assert property (temp_above_85 [*2] ##0 rd_alarm |=> reg_rdata[0])
		else $error("overtemp warning flag missing");
endmodule : fsm_fault_monitor

// *** test/fsm_fault_aggregator_tb_top.sv ***
`timescale 1ns/100ps
module fsm_fault_aggregator_tb_top;
	typedef struct packed {logic [15:0] flags; logic [1:0] lvl;} fsm_row_t;
	logic clk, reset, reg_wr, reg_rd, trim_ld, link, irq, alarm_n;
	logic [7:0] reg_addr, gin;
	logic [15:0] reg_wdata, reg_rdata;
	logic [9:0] ain;
	int err_total, checks_done, cyc;
	// One alarm condition per row: flag word, then {irq, alarm_n} under default masks
	fsm_row_t rows [10] = '{'{16'h0001, 2'h1}, '{16'h0002, 2'h1}, '{16'h0004, 2'h1}, '{16'h0008, 2'h1},
		'{16'h0010, 2'h1}, '{16'h0020, 2'h2}, '{16'h0040, 2'h1}, '{16'h0100, 2'h1}, '{16'h1000, 2'h0}, '{16'h2000, 2'h1}};
	int gpos [8] = '{0, 1, 2, 3, 6, 7, 9, 10};
	// ****************************************
	// Device under test
	// ****************************************
	fsm_fault_aggregator DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .self_diag_fault(ain[9]),
		.oscillator_start_failure(ain[8]), .trim_load_done(trim_ld), .trim_crc_error(ain[7]),
		.link_crc_bad_frame(link), .watchdog_fault(ain[6]), .vref_invalid(ain[5]),
		.aux_input1_out_of_limit(ain[4]), .aux_input0_out_of_limit(ain[3]), .die_temp_out_of_limit(ain[2]),
		.temp_above_130(ain[1]), .temp_above_85(ain[0]), .selftest_done(gin[7]), .selftest_failed(gin[6]),
		.slew_settled(gin[5]), .conversion_done(gin[4]), .break_frame_error(gin[3]),
		.break_parity_error(gin[2]), .serial_frame_error(gin[1]), .serial_parity_error(gin[0]),
		.irq(irq), .alarm_n(alarm_n));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic cmp(logic [15:0] g, logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// Gap cycle after each strobe keeps a strobe from being driven twice in one step
	task automatic wr(logic [7:0] a, logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask : wr
	// Data stand only in the cycle after the strobe, so look at the falling edge there
	task automatic rd(logic [7:0] a, logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp(reg_rdata, e);
		tick(1);
	endtask : rd
	task automatic end_sim;
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard, well above the 272 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		{reset, reg_wr, reg_rd, trim_ld, link} = 5'h1F & 5'h10;
		{reg_addr, gin, reg_wdata, ain} = '0;
		tick(3);
		reset <= 1'b0;
		rd(8'h20, 16'h0200);
		cmp({14'h0, irq, alarm_n}, 16'h0000);
		rd(8'h1D, 16'hEFDF);
		rd(8'h1E, 16'hFFFF);
		rd(8'h40, 16'h0000);
		wr(8'h1E, 16'h0000);
		rd(8'h1E, 16'hF930);
		wr(8'h1E, 16'hFFFF);
		trim_ld <= 1'b1;
		tick(1);
		trim_ld <= 1'b0;
		tick(2);
		rd(8'h20, 16'h0000);
		// Each alarm condition held, then released and cleared
		for (int i = 0; i < 10; i++) begin
			ain <= 10'h001 << i;
			tick(2);
			rd(8'h20, rows[i].flags);
			cmp({14'h0, irq, alarm_n}, {14'h0, rows[i].lvl});
			ain <= '0;
			tick(3);
			rd(8'h20, rows[i].flags & 16'h01C0);
			rd(8'h20, 16'h0000);
		end
		// Each general event, masked then unmasked
		for (int j = 0; j < 8; j++) begin
			gin <= 8'h01 << j;
			tick(2);
			rd(8'h21, 16'h0001 << gpos[j]);
			cmp({14'h0, irq, alarm_n}, 16'h0001);
			wr(8'h1E, ~(16'h0001 << gpos[j]));
			rd(8'h20, 16'h8000);
			cmp({15'h0, irq}, 16'h0001);
			gin <= '0;
			wr(8'h1E, 16'hFFFF);
			rd(8'h20, 16'h0000);
			rd(8'h21, 16'h0000);
		end
		wr(8'h22, 16'h0023);
		rd(8'h20, 16'h0023);
		rd(8'h21, 16'h8000);
		wr(8'h22, 16'h0000);
		link <= 1'b1;
		tick(1);
		link <= 1'b0;
		tick(1);
		rd(8'h20, 16'h0480);
		link <= 1'b1;
		tick(1);
		link <= 1'b0;
		tick(1);
		rd(8'h20, 16'h0880);
		wr(8'h23, 16'h0003);
		rd(8'h20, 16'h0400);
		// Bad frame in the very cycle of a clearing read
		reg_addr <= 8'h20;
		reg_rd <= 1'b1;
		link <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		link <= 1'b0;
		tick(1);
		rd(8'h20, 16'h0480);
		// Back-to-back reads: first clears link flag while a watchdog event lands in it
		link <= 1'b1;
		tick(1);
		link <= 1'b0;
		reg_addr <= 8'h20;
		reg_rd <= 1'b1;
		ain <= 10'h040;
		tick(1);
		ain <= '0;
		@(negedge clk);
		cmp(reg_rdata, 16'h0880);
		tick(1);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp(reg_rdata, 16'h0840);
		tick(1);
		end_sim();
	end
endmodule : fsm_fault_aggregator_tb_top
bind fsm_fault_aggregator fsm_fault_monitor u_mon (.clk, .reset, .reg_addr, .reg_rd, .reg_rdata,
	.self_diag_fault, .oscillator_start_failure, .trim_load_done, .trim_crc_error, .link_crc_bad_frame,
	.watchdog_fault, .temp_above_85, .alarm_n);
